// ===== dv/fdf_peer.sv
// Writer and reader logic facing the buffer ports
`timescale 1ns/100ps
module fdf_peer import fdf_pkg::*; (
    // Clock
    input  wire logic                  aclk,
    // Writer and reader strobes
    output logic                       wr_en_n,
    output logic      [FDF_DATA_W-1:0] wr_data,
    output logic                       rd_en_n
);
    initial begin
        wr_en_n = 1'h1;
        wr_data = '0;
        rd_en_n = 1'h1;
    end
    // =========================================================
    // Writer: n words from d upward, one per edge
    task automatic put(input int n, input logic [FDF_DATA_W-1:0] d);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            wr_en_n <= 1'h0;
            wr_data <= d + FDF_DATA_W'(i);
        end
        @(posedge aclk);
        wr_en_n <= 1'h1;
        // Idle data line does not keep the last word
        wr_data <= ~wr_data;
    endtask
    // =========================================================
    // Reader: n reads back to back
    task automatic take(input int n);
        repeat (n) begin
            @(posedge aclk);
            rd_en_n <= 1'h0;
        end
        @(posedge aclk);
        rd_en_n <= 1'h1;
    endtask
endmodule

// ===== dv/fdf_top_test.sv
// Self-checking bench for the flag-timing buffer
`timescale 1ns/100ps
`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module fdf_top_test import fdf_pkg::*;;
    localparam int D = 16;
    logic                  aclk, aresetn, out_enable_n, ce;
    logic [7:0]            awaddr, araddr;
    logic [31:0]           wdata, rdata, rd_w;
    logic [3:0]            wstrb;
    logic                  awvalid, wvalid, bready, arvalid, rready;
    logic                  awready, wready, bvalid, arready, rvalid;
    logic [1:0]            bresp, rresp, rsp;
    logic                  wr_en_n, rd_en_n, rd_data_oe, irq;
    logic [FDF_DATA_W-1:0] wr_data, rd_data;
    logic                  full_flag_n, empty_flag_n, half_full_flag_n;
    logic                  almost_full_flag_n, almost_empty_flag_n;
    int                    err_total, checked;

    fdf_top #(.DEPTH(D)) fdf_top_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .wr_en_n(wr_en_n), .wr_data(wr_data), .rd_en_n(rd_en_n),
        .out_enable_n(out_enable_n), .rd_data(rd_data),
        .rd_data_oe(rd_data_oe), .full_flag_n(full_flag_n),
        .empty_flag_n(empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n),
        .half_full_flag_n(half_full_flag_n), .irq(irq)
    );
    fdf_peer fdf_peer_inst (
        .aclk(aclk), .wr_en_n(wr_en_n), .wr_data(wr_data),
        .rd_en_n(rd_en_n)
    );
    // =========================================================
    // Bus cycles and helpers
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        bready <= 1'h1;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'h0;
        `CHK(bresp, FDF_RESP_OKAY)
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        rready  <= 1'h1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'h0;
        rd_w = rdata;
        rsp  = rresp;
    endtask
    task automatic nx;
        @(posedge aclk);
        #1;
    endtask
    task automatic rst;
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        nx;
    endtask
    // =========================================================
    // Scenarios
    task automatic t_reset;
        `CHK(rd_data, 18'h0)
        `CHK(rd_data_oe, 1'h0)
        `CHK(empty_flag_n, 1'h0)
        `CHK({full_flag_n, almost_full_flag_n}, 2'h3)
        `CHK(almost_empty_flag_n, 1'h0)
        `CHK(half_full_flag_n, 1'h1)
        @(posedge aclk);
        out_enable_n <= 1'h0;
        nx;
        `CHK(rd_data_oe, 1'h1)
        axr(FDF_A_CTRL);
        `CHK(rd_w, 32'h0)
        axr(FDF_A_AF_OFS);
        `CHK(rd_w, {20'h0, FDF_AF_OFS_RST})
        axr(8'h1c);
        `CHK(rsp, FDF_RESP_DEC)
        axr(FDF_A_IRQ_STAT);
        $display("test reset done");
    endtask
    task automatic t_empty;
        fdf_peer_inst.put(1, 18'h2a5a5);
        #1;
        `CHK(empty_flag_n, 1'h1)
        fdf_peer_inst.take(1);
        #1;
        `CHK(rd_data, 18'h2a5a5)
        `CHK(empty_flag_n, 1'h0)
        fdf_peer_inst.take(1);
        #1;
        `CHK(rd_data, 18'h2a5a5)
        // Write, then read on the very next edge
        fork
            fdf_peer_inst.put(1, 18'h1c3c3);
            begin
                @(posedge aclk);
                fdf_peer_inst.take(1);
            end
        join
        #1;
        `CHK(rd_data, 18'h1c3c3)
        `CHK(empty_flag_n, 1'h0)
        // Writes with the clock enable low must not land
        ce <= 1'h0;
        fdf_peer_inst.put(2, 18'h00f0f);
        ce <= 1'h1;
        nx;
        `CHK(empty_flag_n, 1'h0)
        `CHK(rd_data, 18'h1c3c3)
        axr(FDF_A_IRQ_STAT);
        `CHK(rd_w, 32'ha)
        `CHK(irq, 1'h0)
        $display("test empty boundary done");
    endtask
    task automatic t_fill;
        axw(FDF_A_IRQ_MASK, 32'h5);
        fdf_peer_inst.put(D / 2, 18'h100);
        nx;
        `CHK(half_full_flag_n, 1'h1)
        fdf_peer_inst.put(1, 18'h108);
        nx;
        `CHK(half_full_flag_n, 1'h0)
        `CHK(almost_full_flag_n, 1'h1)
        // Offset 7: low from D - 6 = 10 words
        fdf_peer_inst.put(1, 18'h109);
        nx;
        `CHK(almost_full_flag_n, 1'h0)
        fdf_peer_inst.put(D - 10, 18'h10a);
        #1;
        `CHK(full_flag_n, 1'h0)
        fdf_peer_inst.put(1, 18'h3ffff);
        nx;
        `CHK(irq, 1'h1)
        fdf_peer_inst.take(1);
        #1;
        `CHK(full_flag_n, 1'h1)
        `CHK(rd_data, 18'h100)
        axr(FDF_A_IRQ_STAT);
        `CHK(rd_w, 32'h5)
        nx;
        `CHK(irq, 1'h0)
        for (int i = 1; i < D; i++) begin
            fdf_peer_inst.take(1);
            #1;
            `CHK(rd_data, 18'h100 + 18'(i))
        end
        `CHK(empty_flag_n, 1'h0)
        axw(FDF_A_IRQ_MASK, 32'h0);
        $display("test fill done");
    endtask
    task automatic t_mode;
        fdf_peer_inst.put(8, 18'h200);
        #1;
        `CHK(almost_empty_flag_n, 1'h0)
        nx;
        `CHK(almost_empty_flag_n, 1'h1)
        fdf_peer_inst.take(8);
        nx;
        axw(FDF_A_CTRL, 32'h1);
        fdf_peer_inst.put(8, 18'h210);
        #1;
        `CHK(almost_empty_flag_n, 1'h1)
        fdf_peer_inst.take(8);
        #1;
        `CHK(almost_empty_flag_n, 1'h0)
        $display("test flag mode done");
    endtask
    task automatic t_again;
        // Upper byte strobe only
        wstrb <= 4'h2;
        axw(FDF_A_AF_OFS, 32'hfff);
        wstrb <= 4'hf;
        axr(FDF_A_AF_OFS);
        `CHK(rd_w, 32'hf07)
        axw(FDF_A_AE_OFS, 32'h3);
        fdf_peer_inst.put(3, 18'h300);
        rst;
        `CHK(empty_flag_n, 1'h0)
        `CHK(rd_data, 18'h0)
        axr(FDF_A_AE_OFS);
        `CHK(rd_w, {20'h0, FDF_AE_OFS_RST})
        $display("test second reset done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // =========================================================
    // Clock, watchdog and main sequence
    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        report_and_stop;
    end
    initial begin
        err_total    = 0;
        checked      = 0;
        aresetn      = 1'h0;
        out_enable_n = 1'h1;
        ce           = 1'h1;
        {awaddr, araddr, wdata} = '0;
        wstrb        = 4'hf;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        rst;
        t_reset;
        t_empty;
        t_fill;
        t_mode;
        t_again;
        report_and_stop;
    end
endmodule

// ===== rtl/fdf_mem.sv
// Storage array with registered read data
`timescale 1ns/100ps
module fdf_mem import fdf_pkg::*; #(
    parameter int W     = FDF_DATA_W,
    parameter int DEPTH = FDF_DEPTH,
    parameter int AW    = $clog2(FDF_DEPTH)
) (
    // Clock and control
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // Write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // Read side
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);
    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] rd_data_ff;
    logic [W-1:0] nxt_rd_data;

    // =========================================================
    // Array write
    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // =========================================================
    // Read register, holds the last word between reads
    always_comb begin
        nxt_rd_data = rd_data_ff;
        if (rd_en) begin
            nxt_rd_data = mem[rd_addr];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_ff <= '0;
        end else if (ce) begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;
endmodule

// ===== rtl/fdf_pkg.sv
// Constants shared by the flag-timing buffer and its memory
package fdf_pkg;
    // =========================================================
    // Geometry and reset values
    localparam int          FDF_DATA_W     = 18;
    localparam int          FDF_DEPTH      = 64;
    localparam int          FDF_OFS_W      = 12;
    localparam logic [11:0] FDF_AE_OFS_RST = 12'h007;
    localparam logic [11:0] FDF_AF_OFS_RST = 12'h007;
    localparam logic        FDF_SEL_RST    = 1'h0;
    // =========================================================
    // Timing (single clock: the 5 ns skew rounds up to one period)
    localparam int          FDF_CLK_NS     = 50;
    localparam int          FDF_SKEW_NS    = 5;
    localparam int          FDF_SKEW_CYC   =
        (FDF_SKEW_NS + FDF_CLK_NS - 1) / FDF_CLK_NS;
    // =========================================================
    // Register byte offsets
    localparam logic [7:0]  FDF_A_CTRL     = 8'h00;
    localparam logic [7:0]  FDF_A_AE_OFS   = 8'h04;
    localparam logic [7:0]  FDF_A_AF_OFS   = 8'h08;
    localparam logic [7:0]  FDF_A_STATUS   = 8'h0c;
    localparam logic [7:0]  FDF_A_IRQ_STAT = 8'h10;
    localparam logic [7:0]  FDF_A_IRQ_MASK = 8'h14;
    // =========================================================
    // Field positions
    localparam int          FDF_CTRL_SEL   = 0;
    localparam int          FDF_ST_EMPTY   = 16;
    localparam int          FDF_ST_AE      = 17;
    localparam int          FDF_ST_HF      = 18;
    localparam int          FDF_ST_AF      = 19;
    localparam int          FDF_ST_FULL    = 20;
    localparam int          FDF_IRQ_W      = 4;
    localparam int          FDF_IRQ_FULL   = 0;
    localparam int          FDF_IRQ_EMPTY  = 1;
    localparam int          FDF_IRQ_OVF    = 2;
    localparam int          FDF_IRQ_UNF    = 3;
    localparam logic [3:0]  FDF_MASK_RST   = 4'h0;
    // =========================================================
    // Bus responses
    localparam logic [1:0]  FDF_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  FDF_RESP_DEC   = 2'h3;
endpackage

// ===== rtl/fdf_top.sv
// Buffer with status flags, programmable thresholds and bus slave
//
// Function
// - Full releases at the edge right after a read, skew being met.
// - Empty releases at the edge right after a write, skew being met.
// - Reset works with the clock running throughout the pulse.
// - After reset data reads zero; drive follows output enable low one clock later.
// - First word appears one read after empty goes high.
// - First-read latency bound holds only at the empty boundary.
// - Almost full goes low at capacity minus (m-1) words.
// - Select high updates almost flags at once, low a clock later.
// - Writes are ignored while full is low.
// - Reads are ignored while empty is low; output holds last word.
// - In synchronous mode almost flags move only on clock edges.
`timescale 1ns/100ps
module fdf_top import fdf_pkg::*; #(
    parameter int DEPTH = FDF_DEPTH
) (
    // Clock, reset, enable
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  ce,
    // AXI4-Lite write
    input  wire logic [7:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // AXI4-Lite read
    input  wire logic [7:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // Write port
    input  wire logic                  wr_en_n,
    input  wire logic [FDF_DATA_W-1:0] wr_data,
    // Read port
    input  wire logic                  rd_en_n,
    input  wire logic                  out_enable_n,
    output logic      [FDF_DATA_W-1:0] rd_data,
    output logic                       rd_data_oe,
    // Flags
    output logic                       full_flag_n,
    output logic                       empty_flag_n,
    output logic                       almost_full_flag_n,
    output logic                       almost_empty_flag_n,
    output logic                       half_full_flag_n,
    output logic                       irq
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    logic [AW-1:0]          wr_ptr_ff, nxt_wr_ptr;
    logic [AW-1:0]          rd_ptr_ff, nxt_rd_ptr;
    logic [CW-1:0]          cnt_ff, nxt_cnt, flag_cnt;
    logic                   full_n_ff, nxt_full_n;
    logic                   empty_n_ff, nxt_empty_n;
    logic                   af_n_ff, nxt_af_n;
    logic                   ae_n_ff, nxt_ae_n;
    logic                   hf_n_ff, nxt_hf_n;
    logic                   oe_ff, nxt_oe;
    logic                   do_wr, do_rd, ar_take, wr_exec;
    logic                   sel_ff, nxt_sel;
    logic [FDF_OFS_W-1:0]   ae_ofs_ff, nxt_ae_ofs;
    logic [FDF_OFS_W-1:0]   af_ofs_ff, nxt_af_ofs;
    logic [FDF_IRQ_W-1:0]   stat_ff, nxt_stat, mask_ff, nxt_mask, ev;
    logic                   irq_ff, nxt_irq;
    logic                   aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic [7:0]             aw_addr_ff, nxt_aw_addr;
    logic [31:0]            w_data_ff, nxt_w_data;
    logic [3:0]             w_strb_ff, nxt_w_strb;
    logic                   awready_ff, nxt_awready;
    logic                   wready_ff, nxt_wready;
    logic                   bvalid_ff, nxt_bvalid;
    logic [1:0]             bresp_ff, nxt_bresp;
    logic                   arready_ff, nxt_arready;
    logic                   rvalid_ff, nxt_rvalid;
    logic [31:0]            rdata_ff, nxt_rdata;
    logic [1:0]             rresp_ff, nxt_rresp;

    // =========================================================
    // Storage
    // registered first word
    fdf_mem #(.W(FDF_DATA_W), .DEPTH(DEPTH), .AW(AW)) fdf_mem_inst (
        .clk     (aclk),
        .rst_n   (aresetn),
        .ce      (ce),
        .wr_en   (do_wr),
        .wr_addr (wr_ptr_ff),
        .wr_data (wr_data),
        .rd_en   (do_rd),
        .rd_addr (rd_ptr_ff),
        .rd_data (rd_data)
    );

    // =========================================================
    // Pointers, count and flags
    always_comb begin
        do_wr = !wr_en_n && full_n_ff;
        do_rd = !rd_en_n && empty_n_ff;
        nxt_wr_ptr = do_wr ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
        nxt_rd_ptr = do_rd ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
        unique case ({do_wr, do_rd})
            2'b10: nxt_cnt = CW'(cnt_ff + 1'b1);
            2'b01: nxt_cnt = CW'(cnt_ff - 1'b1);
            default: nxt_cnt = cnt_ff;
        endcase
        nxt_full_n  = int'(nxt_cnt) != DEPTH;
        nxt_empty_n = nxt_cnt != '0;
        flag_cnt = sel_ff ? nxt_cnt : cnt_ff;
        nxt_af_n = int'(flag_cnt) + int'(af_ofs_ff) <= DEPTH;
        nxt_ae_n = int'(flag_cnt) > int'(ae_ofs_ff);
        nxt_hf_n = int'(nxt_cnt) <= DEPTH / 2;
        nxt_oe   = !out_enable_n;
        ev = '0;
        ev[FDF_IRQ_FULL]  = full_n_ff && !nxt_full_n;
        ev[FDF_IRQ_EMPTY] = empty_n_ff && !nxt_empty_n;
        ev[FDF_IRQ_OVF]   = !wr_en_n && !full_n_ff;
        ev[FDF_IRQ_UNF]   = !rd_en_n && !empty_n_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_ff  <= '0;
            rd_ptr_ff  <= '0;
            cnt_ff     <= '0;
            full_n_ff  <= 1'b1;
            empty_n_ff <= 1'b0;
            af_n_ff    <= 1'b1;
            ae_n_ff    <= 1'b0;
            hf_n_ff    <= 1'b1;
            oe_ff      <= 1'b0;
        end else if (ce) begin
            wr_ptr_ff  <= nxt_wr_ptr;
            rd_ptr_ff  <= nxt_rd_ptr;
            cnt_ff     <= nxt_cnt;
            full_n_ff  <= nxt_full_n;
            empty_n_ff <= nxt_empty_n;
            af_n_ff    <= nxt_af_n;
            ae_n_ff    <= nxt_ae_n;
            hf_n_ff    <= nxt_hf_n;
            oe_ff      <= nxt_oe;
        end
    end

    // =========================================================
    // Register slave
    always_comb begin
        nxt_aw_got  = aw_got_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_got   = w_got_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        nxt_sel     = sel_ff;
        nxt_ae_ofs  = ae_ofs_ff;
        nxt_af_ofs  = af_ofs_ff;
        nxt_mask    = mask_ff;
        nxt_stat    = stat_ff;
        if (awvalid && awready_ff) begin
            nxt_aw_got  = 1'b1;
            nxt_aw_addr = awaddr;
        end
        if (wvalid && wready_ff) begin
            nxt_w_got  = 1'b1;
            nxt_w_data = wdata;
            nxt_w_strb = wstrb;
        end
        if (bvalid_ff && bready) nxt_bvalid = 1'b0;
        wr_exec = aw_got_ff && w_got_ff && !bvalid_ff;
        if (wr_exec) begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = FDF_RESP_OKAY;
            unique case (aw_addr_ff)
                FDF_A_CTRL:
                    if (w_strb_ff[0]) nxt_sel = w_data_ff[FDF_CTRL_SEL];
                FDF_A_AE_OFS: begin
                    if (w_strb_ff[0]) nxt_ae_ofs[7:0] = w_data_ff[7:0];
                    if (w_strb_ff[1]) nxt_ae_ofs[11:8] = w_data_ff[11:8];
                end
                FDF_A_AF_OFS: begin
                    if (w_strb_ff[0]) nxt_af_ofs[7:0] = w_data_ff[7:0];
                    if (w_strb_ff[1]) nxt_af_ofs[11:8] = w_data_ff[11:8];
                end
                FDF_A_IRQ_MASK:
                    if (w_strb_ff[0]) nxt_mask = w_data_ff[FDF_IRQ_W-1:0];
                FDF_A_STATUS, FDF_A_IRQ_STAT: ;
                default: nxt_bresp = FDF_RESP_DEC;
            endcase
        end
        if (rvalid_ff && rready) nxt_rvalid = 1'b0;
        ar_take = arvalid && arready_ff;
        if (ar_take) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = FDF_RESP_OKAY;
            nxt_rdata  = '0;
            unique case (araddr)
                FDF_A_CTRL:     nxt_rdata[FDF_CTRL_SEL] = sel_ff;
                FDF_A_AE_OFS:   nxt_rdata[FDF_OFS_W-1:0] = ae_ofs_ff;
                FDF_A_AF_OFS:   nxt_rdata[FDF_OFS_W-1:0] = af_ofs_ff;
                FDF_A_STATUS: begin
                    nxt_rdata[CW-1:0]         = cnt_ff;
                    nxt_rdata[FDF_ST_EMPTY]   = empty_n_ff;
                    nxt_rdata[FDF_ST_AE]      = ae_n_ff;
                    nxt_rdata[FDF_ST_HF]      = hf_n_ff;
                    nxt_rdata[FDF_ST_AF]      = af_n_ff;
                    nxt_rdata[FDF_ST_FULL]    = full_n_ff;
                end
                FDF_A_IRQ_STAT: begin
                    nxt_rdata[FDF_IRQ_W-1:0] = stat_ff;
                    nxt_stat = '0;
                end
                FDF_A_IRQ_MASK: nxt_rdata[FDF_IRQ_W-1:0] = mask_ff;
                default:        nxt_rresp = FDF_RESP_DEC;
            endcase
        end
        // New events win over a read clear
        nxt_stat    = nxt_stat | ev;
        nxt_irq     = |(nxt_stat & nxt_mask);
        nxt_awready = !nxt_aw_got && !nxt_bvalid;
        nxt_wready  = !nxt_w_got && !nxt_bvalid;
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            aw_addr_ff <= '0;
            w_got_ff   <= 1'b0;
            w_data_ff  <= '0;
            w_strb_ff  <= '0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= FDF_RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= FDF_RESP_OKAY;
            sel_ff     <= FDF_SEL_RST;
            ae_ofs_ff  <= FDF_AE_OFS_RST;
            af_ofs_ff  <= FDF_AF_OFS_RST;
            mask_ff    <= FDF_MASK_RST;
            stat_ff    <= '0;
            irq_ff     <= 1'b0;
        end else if (ce) begin
            aw_got_ff  <= nxt_aw_got;
            aw_addr_ff <= nxt_aw_addr;
            w_got_ff   <= nxt_w_got;
            w_data_ff  <= nxt_w_data;
            w_strb_ff  <= nxt_w_strb;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
            sel_ff     <= nxt_sel;
            ae_ofs_ff  <= nxt_ae_ofs;
            af_ofs_ff  <= nxt_af_ofs;
            mask_ff    <= nxt_mask;
            stat_ff    <= nxt_stat;
            irq_ff     <= nxt_irq;
        end
    end

    // =========================================================
    // Outputs
    assign awready             = awready_ff;
    assign wready              = wready_ff;
    assign bvalid              = bvalid_ff;
    assign bresp               = bresp_ff;
    assign arready             = arready_ff;
    assign rvalid              = rvalid_ff;
    assign rdata               = rdata_ff;
    assign rresp               = rresp_ff;
    assign rd_data_oe          = oe_ff;
    assign full_flag_n         = full_n_ff;
    assign empty_flag_n        = empty_n_ff;
    assign almost_full_flag_n  = af_n_ff;
    assign almost_empty_flag_n = ae_n_ff;
    assign half_full_flag_n    = hf_n_ff;
    assign irq                 = irq_ff;

    // =========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    full_block_a: assert property (
        ce && !full_n_ff && !wr_en_n |=> $stable(wr_ptr_ff))
        else $error("write taken while full");
    empty_hold_a: assert property (
        ce && !empty_n_ff |=> $stable(rd_data) && $stable(rd_ptr_ff))
        else $error("read taken while empty");
    full_release_a: assert property (
        ce && !full_n_ff && !rd_en_n |=> full_n_ff)
        else $error("full flag did not release");
    empty_release_a: assert property (
        ce && !empty_n_ff && !wr_en_n |=> empty_n_ff)
        else $error("empty flag did not release");
    first_word_a: assert property (
        ce && !empty_n_ff && !wr_en_n ##1 ce && !rd_en_n
        |=> rd_data == $past(wr_data, 2))
        else $error("first word late or wrong");
    reset_out_a: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> rd_data == '0 && cnt_ff == '0 && !empty_n_ff)
        else $error("reset state wrong");
    af_level_a: assert property (
        sel_ff && $stable(sel_ff) && $stable(af_ofs_ff) |->
        af_n_ff == (int'(cnt_ff) + int'(af_ofs_ff) <= DEPTH))
        else $error("almost full mismatch");
    sync_lag_a: assert property (
        ce && !sel_ff && !$past(sel_ff) && $past(ce)
        && $stable(ae_ofs_ff) |->
        ##1 ae_n_ff == (int'($past(cnt_ff)) > int'(ae_ofs_ff)))
        else $error("almost empty lag wrong");
    half_full_a: assert property (
        hf_n_ff == (int'(cnt_ff) <= DEPTH / 2))
        else $error("half full mismatch");
    irq_line_a: assert property (
        irq_ff == |(stat_ff & mask_ff))
        else $error("interrupt line mismatch");
    bvalid_hold_a: assert property (
        bvalid_ff && !bready |=> bvalid_ff)
        else $error("write response dropped");
    fill_c:  cover property (ce && !full_n_ff);
    leave_c: cover property (!empty_n_ff ##1 empty_n_ff);
    irq_c:   cover property ($rose(irq_ff));
    af_c:    cover property ($fell(af_n_ff));
endmodule
